//--- design/dlcim_pkg.sv
// Package for the data link control and interrupt-mask block.
// Assumes a 32-bit APB bus where each register index sits at byte address four times the index.
package dlcim_pkg;
  // Bus geometry.
  localparam int          APB_AW          = 14;
  localparam int          IDX_W           = 12;
  // Register indices; the byte address is four times the index.
  localparam logic [11:0] IDX_LINK_MODE   = 12'h800;
  localparam logic [11:0] IDX_LINK_CTRL   = 12'h801;
  localparam logic [11:0] IDX_LINK_IEN    = 12'h802;
  localparam logic [11:0] IDX_LINK_TXCFG  = 12'h803;
  localparam logic [11:0] IDX_LINK_TMODE  = 12'h809;
  localparam logic [11:0] IDX_LINK_STAT   = 12'h80B;
  // Fields of link_control.
  localparam int          CTL_REMOTE_LOOP = 0;
  localparam int          CTL_LOCAL_LOOP  = 1;
  localparam int          CTL_RX_EN       = 2;
  localparam int          CTL_TX_EN       = 3;
  localparam int          CTL_RX_RST      = 4;
  localparam int          CTL_TX_RST      = 5;
  localparam int          CTL_RX_KEEP     = 6;
  localparam int          CTL_TX_REPORT   = 7;
  // Fields of link_interrupt_enable and of the status register.
  localparam int          EV_TX_DONE      = 0;
  localparam int          EV_TX_EMPTY     = 1;
  localparam int          EV_TX_UNDERRUN  = 2;
  localparam int          EV_RX_FULL      = 3;
  localparam int          EV_RX_FRAME_END = 4;
  localparam int          EV_RX_OVERRUN   = 5;
  localparam int          EV_RX_IDLE      = 6;
  localparam int          IEN_BAD_CHECK   = 7;
  localparam int          NUM_EV          = 7;
  localparam logic [6:0]  RX_EV_MASK      = 7'h78;
  // Fields of the mode and transparent-mode registers.
  localparam int          MODE_DYN_IRQ    = 0;
  localparam int          MODE_FLAG_FILL  = 1;
  localparam int          TMODE_TRANSP    = 6;
  // Values after reset.
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  // Fill bytes.
  localparam logic [7:0]  FILL_IDLE       = 8'hFF;
  localparam logic [7:0]  FILL_FLAG       = 8'h7E;
  // Register index decode shared by every register.
  function automatic logic idx_hit(input logic [APB_AW-1:0] addr, input logic [11:0] idx);
    idx_hit = (addr[APB_AW-1:2] == idx);
  endfunction
endpackage

//--- design/dlcim_top.sv
// Control, loopback routing and interrupt masking of the facility link channel.
// Assumes an APB master on clk, and a framer and an HDLC core on the same clock (no synchronisers).
//
// How it works
// - Remote loop bit 0 sends received link bits back out on transmit.
// - Local loop bit 1 feeds transmit bits to receiver, ignores framer bits but not framer strobe.
// - Receiver runs only while receive enable bit 2 is one; resets to zero.
// - Transmitter runs only while transmit enable bit 3 is one; resets to zero.
// - Receiver reset bit 4 pulses, clearing receive FIFO and four receive flags.
// - Transmitter reset bit 5 pulses; clears underrun, sets empty, done follows mode.
// - Bit 6 makes receiver keep whole report frames with header and check bytes.
// - Bit 7 loads the framer's report into the transmit FIFO once a second.
// - With bit 7 clear, transmit FIFO takes only processor-written bytes.
// - Done enable raises interrupt after closing flag or abort in HDLC mode.
// - In transparent mode done fires when transmit FIFO is completely empty.
// - Empty enable raises interrupt at the programmed transmit empty level.
// - Underrun enable raises interrupt on underrun; ignored in transparent mode.
// - Full enable raises interrupt at the programmed receive full level.
// - Frame-end enable raises interrupt at frame end; unused in transparent mode.
// - Overrun enable raises interrupt whenever the receive FIFO overruns.
// - Idle enable raises interrupt on receiver idle; unused in transparent mode.
// - Mask bit 7 forces corrupted check sequences on every frame while set.
// - All interrupt enables clear to zero at hardware reset.
// - Static mode gives one interrupt until status read; dynamic interrupts each event.
// - With nothing to send, transmitter fills with all-ones or flag bytes.
`timescale 1ns/1ps
module dlcim_top
  import dlcim_pkg::*;
(
  // Clock and reset.
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // APB slave.
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [dlcim_pkg::APB_AW-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Framer side of the link bit stream.
  input  wire logic                        framerRxBit,
  input  wire logic                        framerBitStb,
  output logic                             linkTxBit,
  // HDLC core bit stream.
  input  wire logic                        coreTxBit,
  output logic                             coreRxBit,
  output logic                             coreRxStb,
  // Transmit FIFO load sources.
  input  wire logic [7:0]                  cpuByte,
  input  wire logic                        cpuByteValid,
  input  wire logic [7:0]                  reportByte,
  input  wire logic                        reportByteValid,
  output logic      [7:0]                  txLoadByte,
  output logic                             txLoadValid,
  // Controls to the HDLC core.
  output logic                             linkRxEnable,
  output logic                             linkTxEnable,
  output logic                             linkRxSoftReset,
  output logic                             linkTxSoftReset,
  output logic                             rxReportFramesKeep,
  output logic                             txReportSourceSel,
  output logic                             txCorruptCheckTest,
  output logic                             transparentMode,
  output logic      [7:0]                  txFillByte,
  output logic      [7:0]                  txConfig,
  // Events from the HDLC core, one-cycle pulses.
  input  wire logic                        txDoneEvt,
  input  wire logic                        txFifoDrainedEvt,
  input  wire logic                        txEmptyEvt,
  input  wire logic                        txUnderrunEvt,
  input  wire logic                        rxFullEvt,
  input  wire logic                        rxFrameEndEvt,
  input  wire logic                        rxOverrunEvt,
  input  wire logic                        rxIdleEvt,
  // Interrupt.
  output logic                             irqOut
);
  import dlcim_pkg::*;

  logic [7:0]        ctl_r;
  logic [7:0]        ien_r;
  logic [7:0]        txcfg_r;
  logic [1:0]        mode_r;
  logic              transp_r;
  logic [NUM_EV-1:0] flags_r;
  logic [NUM_EV-1:0] flags_nxt;
  logic [31:0]       prdata_r;
  logic              irq_r;
  logic              rxRst_r;
  logic              txRst_r;
  logic              linkTx_r;
  logic              coreRx_r;
  logic              coreRxStb_r;
  logic [7:0]        load_r;
  logic              loadValid_r;
  logic [7:0]        fill_r;

  // Address decode; the setup cycle latches read data so that prdata comes from flops.
  wire setupPh  = psel & ~penable;
  wire accessPh = psel & penable;
  wire hitMode  = idx_hit(paddr, IDX_LINK_MODE);
  wire hitCtl   = idx_hit(paddr, IDX_LINK_CTRL);
  wire hitIen   = idx_hit(paddr, IDX_LINK_IEN);
  wire hitTxcfg = idx_hit(paddr, IDX_LINK_TXCFG);
  wire hitTmode = idx_hit(paddr, IDX_LINK_TMODE);
  wire hitStat  = idx_hit(paddr, IDX_LINK_STAT);
  wire mapped   = hitMode | hitCtl | hitIen | hitTxcfg | hitTmode | hitStat;
  wire wrEn     = accessPh & pwrite & mapped;
  wire statRead = accessPh & ~pwrite & hitStat;

  // Read mux; reserved bits and bits above the byte read as zero.
  wire [7:0] rdByte = hitMode  ? {6'h00, mode_r} :
                      hitCtl   ? ctl_r :
                      hitIen   ? ien_r :
                      hitTxcfg ? txcfg_r :
                      hitTmode ? {1'b0, transp_r, 6'h00} :
                      hitStat  ? {1'b0, flags_r} : 8'h00;

  assign pready  = 1'b1;
  assign pslverr = accessPh & ~mapped;
  assign prdata  = prdata_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (setupPh) begin
      prdata_r <= {24'h00_0000, rdByte};
    end
  end

  // Writable registers; the two soft-reset bits never stay set and read back zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_r    <= RST_BYTE;
      ien_r    <= RST_BYTE; // mask reset: every enable off.
      txcfg_r  <= RST_BYTE;
      mode_r   <= 2'h0;
      transp_r <= 1'b0;
    end else if (wrEn) begin
      if (hitCtl) ctl_r <= pwdata[7:0] & 8'hCF;
      if (hitIen) ien_r <= pwdata[7:0];
      if (hitTxcfg) txcfg_r <= pwdata[7:0];
      if (hitMode) mode_r <= pwdata[1:0];
      if (hitTmode) transp_r <= pwdata[TMODE_TRANSP];
    end
  end

  // receiver reset: one-cycle pulse per write of one.
  // transmitter reset: one-cycle pulse per write of one.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxRst_r <= 1'b0;
      txRst_r <= 1'b0;
    end else begin
      rxRst_r <= wrEn & hitCtl & pwdata[CTL_RX_RST];
      txRst_r <= wrEn & hitCtl & pwdata[CTL_TX_RST];
    end
  end

  assign linkRxEnable       = ctl_r[CTL_RX_EN];
  assign linkTxEnable       = ctl_r[CTL_TX_EN];
  assign linkRxSoftReset    = rxRst_r;
  assign linkTxSoftReset    = txRst_r;
  // report keeping: steers the receiver's FIFO writes.
  assign rxReportFramesKeep = ctl_r[CTL_RX_KEEP];
  assign txReportSourceSel  = ctl_r[CTL_TX_REPORT];
  // corrupt check: level held while the test bit is set.
  assign txCorruptCheckTest = ien_r[IEN_BAD_CHECK];
  assign transparentMode    = transp_r;
  assign txConfig           = txcfg_r;

  // Loop paths. A disabled direction is forced to the mark level, transmit only with remote loop off, so each side sees idle line.
  wire rxSrcBit = ctl_r[CTL_LOCAL_LOOP] ? coreTxBit : framerRxBit;
  wire txSrcBit = ctl_r[CTL_TX_EN] ? coreTxBit : 1'b1;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      linkTx_r    <= 1'b1;
      coreRx_r    <= 1'b1;
      coreRxStb_r <= 1'b0;
    end else begin
      // remote loop: received bit goes back out.
      linkTx_r    <= ctl_r[CTL_REMOTE_LOOP] ? framerRxBit : txSrcBit;
      // local loop, receive enable: framer bit ignored or receiver idle.
      coreRx_r    <= ctl_r[CTL_RX_EN] ? rxSrcBit : 1'b1;
      coreRxStb_r <= ctl_r[CTL_RX_EN] & framerBitStb;
    end
  end
  assign linkTxBit = linkTx_r;
  assign coreRxBit = coreRx_r;
  assign coreRxStb = coreRxStb_r;

  // Transmit FIFO load source. The report source is owned by the framer, which paces it per second.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      load_r      <= RST_BYTE;
      loadValid_r <= 1'b0;
    end else if (ctl_r[CTL_TX_REPORT]) begin
      // report source: framer report bytes only.
      load_r      <= reportByte;
      loadValid_r <= reportByteValid;
    end else begin
      load_r      <= cpuByte;
      loadValid_r <= cpuByteValid;
    end
  end
  assign txLoadByte  = load_r;
  assign txLoadValid = loadValid_r;

  // fill byte: all-ones idle or flags when nothing is pending.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fill_r <= FILL_IDLE;
    end else begin
      fill_r <= mode_r[MODE_FLAG_FILL] ? FILL_FLAG : FILL_IDLE;
    end
  end
  assign txFillByte = fill_r;

  // Event vector. Transparent mode retargets done and silences the HDLC-only events.
  logic [NUM_EV-1:0] ev;
  assign ev[EV_TX_DONE]      = transp_r ? txFifoDrainedEvt : txDoneEvt;
  assign ev[EV_TX_EMPTY]     = txEmptyEvt;
  assign ev[EV_TX_UNDERRUN]  = txUnderrunEvt & ~transp_r;
  assign ev[EV_RX_FULL]      = rxFullEvt;
  assign ev[EV_RX_FRAME_END] = rxFrameEndEvt & ~transp_r;
  assign ev[EV_RX_OVERRUN]   = rxOverrunEvt;
  assign ev[EV_RX_IDLE]      = rxIdleEvt & ~transp_r;

  // Clears from a status read and the soft resets; a new event in the same cycle still wins.
  wire [NUM_EV-1:0] clrMask = (statRead ? 7'h7F : 7'h00) | (rxRst_r ? RX_EV_MASK : 7'h00) |
                              (txRst_r ? 7'h07 : 7'h00);
  wire [NUM_EV-1:0] rstSet  = txRst_r ? {5'h00, 1'b1, transp_r} : 7'h00;
  assign flags_nxt = (flags_r & ~clrMask) | rstSet | ev;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= 7'h00;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // interrupt gating and dynamic mode: static holds a level, dynamic pulses per event.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else if (mode_r[MODE_DYN_IRQ]) begin
      irq_r <= |(ev & ien_r[NUM_EV-1:0]);
    end else begin
      irq_r <= |(flags_nxt & ien_r[NUM_EV-1:0]);
    end
  end
  assign irqOut = irq_r;

  // Checks.
  remote_loop_a: assert property (@(posedge clk) disable iff (!rst_n)
    ctl_r[CTL_REMOTE_LOOP] |=> linkTxBit == $past(framerRxBit))
    else $error("Remote loop did not return the received bit.");

  local_loop_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ctl_r[CTL_RX_EN] && ctl_r[CTL_LOCAL_LOOP]) |=> coreRxBit == $past(coreTxBit))
    else $error("Local loop did not feed transmit bits to the receiver.");

  rx_disabled_a: assert property (@(posedge clk) disable iff (!rst_n)
    !ctl_r[CTL_RX_EN] |=> (!coreRxStb && coreRxBit))
    else $error("Receiver saw bits while disabled.");

  tx_disabled_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!ctl_r[CTL_TX_EN] && !ctl_r[CTL_REMOTE_LOOP]) |=> linkTxBit)
    else $error("Transmitter drove data while disabled.");

  rx_reset_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wrEn && hitCtl && pwdata[CTL_RX_RST]) |=> linkRxSoftReset ##1
      ((flags_r & RX_EV_MASK) == ($past(ev) & RX_EV_MASK)))
    else $error("Receiver reset did not clear the receive flags.");

  tx_reset_flags_a: assert property (@(posedge clk) disable iff (!rst_n)
    linkTxSoftReset |=> (flags_r[EV_TX_EMPTY] && !(flags_r[EV_TX_UNDERRUN] && !$past(ev[EV_TX_UNDERRUN]))
      && flags_r[EV_TX_DONE] == ($past(transp_r) | $past(ev[EV_TX_DONE]))))
    else $error("Transmitter reset left wrong status.");

  report_source_a: assert property (@(posedge clk) disable iff (!rst_n)
    ctl_r[CTL_TX_REPORT] |=> (txLoadByte == $past(reportByte) && txLoadValid == $past(reportByteValid)))
    else $error("Report source not routed to the transmit FIFO.");

  cpu_source_a: assert property (@(posedge clk) disable iff (!rst_n)
    !ctl_r[CTL_TX_REPORT] |=> txLoadValid == $past(cpuByteValid))
    else $error("Processor bytes not routed to the transmit FIFO.");

  transp_underrun_a: assert property (@(posedge clk) disable iff (!rst_n)
    (transp_r && !flags_r[EV_TX_UNDERRUN] && !txRst_r) |=> !flags_r[EV_TX_UNDERRUN])
    else $error("Underrun latched in transparent mode.");

  fill_byte_a: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(mode_r[MODE_FLAG_FILL]) |=> txFillByte == (mode_r[MODE_FLAG_FILL] ? FILL_FLAG : FILL_IDLE))
    else $error("Fill byte does not follow the flag-fill bit.");

  static_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (irqOut && !mode_r[MODE_DYN_IRQ] && !statRead && !txRst_r && !rxRst_r && $stable(ien_r)) |=> irqOut)
    else $error("Static interrupt dropped before the status read.");

  irq_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!mode_r[MODE_DYN_IRQ] && $past(!mode_r[MODE_DYN_IRQ])) |-> irqOut == |($past(flags_nxt) & $past(ien_r[NUM_EV-1:0])))
    else $error("Interrupt output not the gated flag OR.");

  done_hdlc_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!transp_r && txDoneEvt) |=> flags_r[EV_TX_DONE])
    else $error("Closing flag done event not latched.");

  done_transp_a: assert property (@(posedge clk) disable iff (!rst_n)
    (transp_r && txFifoDrainedEvt) |=> flags_r[EV_TX_DONE])
    else $error("Drained FIFO did not latch done in transparent mode.");

  empty_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
    txEmptyEvt |=> flags_r[EV_TX_EMPTY])
    else $error("Transmit empty level event not latched.");

  full_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
    rxFullEvt |=> flags_r[EV_RX_FULL])
    else $error("Receive full level event not latched.");

  overrun_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
    rxOverrunEvt |=> flags_r[EV_RX_OVERRUN])
    else $error("Receive overrun event not latched.");

  cov_remote_c: cover property (@(posedge clk) disable iff (!rst_n) ctl_r[CTL_REMOTE_LOOP] && framerBitStb);
  cov_irq_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(irqOut) ##[1:20] statRead);
  cov_txrst_c: cover property (@(posedge clk) disable iff (!rst_n) linkTxSoftReset && transp_r);
  cov_dyn_c: cover property (@(posedge clk) disable iff (!rst_n) mode_r[MODE_DYN_IRQ] && irqOut);
endmodule // dlcim_top

//--- test/data_link_ctrl_irq_mask_tb.sv
// Self-checking bench of the link control and interrupt-mask block against an integer model.
// Assumes the design and its package are compiled first.
`timescale 1ns/1ps
module data_link_ctrl_irq_mask_tb;
  import dlcim_pkg::*;
  logic              clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata, prdata;
  logic              frBit, frStb, linkTxBit, coreTxBit, coreRxBit, coreRxStb;
  logic [7:0]        cpuByte, repByte, txLoadByte, txFillByte, txConfig;
  logic              cpuValid, repValid, txLoadValid, drained, irqOut;
  logic              rxEn, txEn, rxRst, txRst, keep, repSel, badChk, transp;
  logic [6:0]        evt;
  int                fails, cmp_count, ctlM, ienM, tmM, statM, c;
  localparam logic [11:0] REGS [6] = '{IDX_LINK_MODE, IDX_LINK_CTRL, IDX_LINK_IEN,
                                       IDX_LINK_TXCFG, IDX_LINK_TMODE, IDX_LINK_STAT};
  localparam logic [7:0]  MODES [7] = '{8'h00, 8'h0C, 8'h0D, 8'h0E, 8'h08, 8'h8C, 8'hCC};

  dlcim_framer_model i_dlcim_framer_model (.clk(clk), .rst_n(rst_n), .framerRxBit(frBit),
    .framerBitStb(frStb), .reportByte(repByte), .reportByteValid(repValid));
  dlcim_top i_dlcim_top (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .framerRxBit(frBit), .framerBitStb(frStb), .linkTxBit(linkTxBit), .coreTxBit(coreTxBit),
    .coreRxBit(coreRxBit), .coreRxStb(coreRxStb), .cpuByte(cpuByte), .cpuByteValid(cpuValid),
    .reportByte(repByte), .reportByteValid(repValid), .txLoadByte(txLoadByte),
    .txLoadValid(txLoadValid), .linkRxEnable(rxEn), .linkTxEnable(txEn), .linkRxSoftReset(rxRst),
    .linkTxSoftReset(txRst), .rxReportFramesKeep(keep), .txReportSourceSel(repSel),
    .txCorruptCheckTest(badChk), .transparentMode(transp), .txFillByte(txFillByte),
    .txConfig(txConfig), .txDoneEvt(evt[0]), .txFifoDrainedEvt(drained), .txEmptyEvt(evt[1]),
    .txUnderrunEvt(evt[2]), .rxFullEvt(evt[3]), .rxFrameEndEvt(evt[4]), .rxOverrunEvt(evt[5]),
    .rxIdleEvt(evt[6]), .irqOut(irqOut));

  // Free-running 250 MHz clock.
  always #2 clk = ~clk;

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Values are compared four-state, so an unknown never passes.
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high at an edge.
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask

  task automatic rdc(input logic [11:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 8'h00, r, e);
    cmp(r, exp, "read data");
  endtask

  // Reading status clears the flags in the model too.
  task automatic rd_stat();
    rdc(IDX_LINK_STAT, statM);
    statM = 0;
  endtask

  // One-cycle event pulses; transparent mode drops underrun, frame end and idle.
  task automatic pulse(input logic [6:0] v, input logic dr);
    @(posedge clk);
    evt     <= v;
    drained <= dr;
    @(posedge clk);
    evt     <= 7'h00;
    drained <= 1'b0;
    statM |= tmM[6] ? ((v & 7'h2A) | dr) : v;
    #1;
  endtask

  // Link routing and load source checked every cycle against the previous edge's inputs.
  task automatic stream(input int n);
    logic eTx, eRx, eV;
    logic [7:0] eB;
    repeat (n) begin
      @(posedge clk);
      eTx = ctlM[0] ? frBit : (ctlM[3] ? coreTxBit : 1'b1);
      eRx = !ctlM[2] ? 1'b1 : (ctlM[1] ? coreTxBit : frBit);
      eV = ctlM[7] ? repValid : cpuValid;
      eB = ctlM[7] ? repByte : cpuByte;
      c = ctlM[2] & frStb;
      coreTxBit <= 1'($urandom);
      cpuValid  <= 1'($urandom);
      cpuByte   <= 8'($urandom);
      #1;
      cmp(linkTxBit, eTx, "link tx bit");
      cmp(coreRxBit, eRx, "core rx bit");
      if (!ctlM[1]) cmp(coreRxStb, c, "core rx strobe");
      cmp(txLoadValid, eV, "load valid");
      if (eV) cmp(txLoadByte, eB, "load byte");
    end
  endtask

  task automatic cnt_irq();
    c = (irqOut === 1'b1);
    repeat (3) begin
      @(posedge clk);
      #1;
      c += (irqOut === 1'b1);
    end
  endtask

  // Hang guard: far beyond the few hundred cycles the tests need.
  initial begin
    #100000;
    fails++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    logic [31:0] r;
    logic e;
    logic [7:0] v;
    clk = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    coreTxBit = 1'b0; cpuByte = 8'h00; cpuValid = 1'b0; evt = 7'h00; drained = 1'b0;
    ctlM = 0; ienM = 0; tmM = 0; statM = 0;
    void'($urandom(9));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    cmp({rxEn, txEn, keep, repSel, badChk, transp, irqOut}, 0, "reset levels");
    cmp({linkTxBit, txFillByte}, 9'h1FF, "reset fill");
    foreach (REGS[k]) rdc(REGS[k], 0);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      v = 8'($urandom) & 8'hCF;
      wr(IDX_LINK_CTRL, v);
      ctlM = v;
      rdc(IDX_LINK_CTRL, v);
      cmp({repSel, keep, txEn, rxEn}, {v[7], v[6], v[3], v[2]}, "ctl levels");
      v = 8'($urandom);
      wr(IDX_LINK_IEN, v);
      rdc(IDX_LINK_IEN, v);
      cmp({badChk, irqOut}, {v[7], 1'b0}, "bad check");
      v = ~v;
      wr(IDX_LINK_TXCFG, v);
      rdc(IDX_LINK_TXCFG, v);
      cmp(txConfig, v, "tx config");
    end
    apb(1'b1, 12'h7FF, 8'h5A, r, e);
    cmp(e, 1, "unmapped write");
    apb(1'b0, 12'h7FF, 8'h00, r, e);
    cmp(e, 1, "unmapped read error");
    cmp(r, 0, "unmapped read data");
    wr(IDX_LINK_STAT, 8'hFF);
    rd_stat();
    wr(IDX_LINK_TMODE, 8'h40);
    #1 cmp(transp, 1, "transparent level");
    wr(IDX_LINK_TMODE, 8'h00);
    $display("test registers done");
    foreach (MODES[k]) begin
      wr(IDX_LINK_CTRL, MODES[k]);
      ctlM = MODES[k];
      stream(40);
    end
    $display("test routing done");
    wr(IDX_LINK_MODE, 8'h02);
    repeat (2) @(posedge clk);
    #1 cmp(txFillByte, FILL_FLAG, "flag fill");
    wr(IDX_LINK_MODE, 8'h00);
    repeat (2) @(posedge clk);
    #1 cmp(txFillByte, FILL_IDLE, "idle fill");
    $display("test fill done");
    for (int i = 0; i < 7; i++) begin
      wr(IDX_LINK_IEN, 8'h00);
      ienM = 0;
      pulse(7'(1 << i), 1'b0);
      cmp(irqOut, 0, "masked event");
      rd_stat();
      wr(IDX_LINK_IEN, 8'(1 << i));
      ienM = 1 << i;
      pulse(7'(1 << i), 1'b0);
      pulse(7'(1 << i), 1'b0);
      cmp(irqOut, 1, "enabled event");
      rd_stat();
      @(posedge clk);
      #1 cmp(irqOut, 0, "irq after read");
    end
    wr(IDX_LINK_MODE, 8'h01);
    wr(IDX_LINK_IEN, 8'h7F);
    repeat (2) begin
      pulse(7'h08, 1'b0);
      cnt_irq();
      cmp(c, 1, "dynamic pulses");
    end
    rd_stat();
    wr(IDX_LINK_MODE, 8'h00);
    $display("test interrupts done");
    wr(IDX_LINK_TMODE, 8'h40);
    tmM = 8'h40;
    pulse(7'h7F, 1'b0);
    rd_stat();
    pulse(7'h00, 1'b1);
    cmp(irqOut, 1, "drained done");
    rd_stat();
    wr(IDX_LINK_CTRL, 8'h20);
    statM = 3;
    rd_stat();
    wr(IDX_LINK_TMODE, 8'h00);
    tmM = 0;
    wr(IDX_LINK_IEN, 8'h00);
    $display("test transparent done");
    pulse(7'h7F, 1'b0);
    wr(IDX_LINK_CTRL, 8'h10);
    #1 cmp(rxRst, 1, "rx reset pulse");
    @(posedge clk);
    #1 cmp(rxRst, 0, "rx reset end");
    statM &= ~RX_EV_MASK;
    rdc(IDX_LINK_CTRL, 0);
    rd_stat();
    pulse(7'h7F, 1'b0);
    wr(IDX_LINK_CTRL, 8'h20);
    #1 cmp(txRst, 1, "tx reset pulse");
    @(posedge clk);
    #1 cmp(txRst, 0, "tx reset end");
    statM = (statM & ~5) | 2;
    rd_stat();
    $display("test soft resets done");
    report_and_stop();
  end
endmodule // data_link_ctrl_irq_mask_tb

//--- test/dlcim_framer_model.sv
// Behavioural framer model: the link bit stream with its strobe, and report bytes.
// Assumes it runs on the block's clock and is reset with it.
`timescale 1ns/1ps
module dlcim_framer_model #(
  parameter int STB_DIV = 3
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Link stream and report bytes.
  output logic            framerRxBit,
  output logic            framerBitStb,
  output logic [7:0]      reportByte,
  output logic            reportByteValid
);
  int divCnt;
  // The bit line takes a new random value every cycle, so a stale bit cannot keep matching by luck.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt          <= 0;
      framerRxBit     <= 1'b1;
      framerBitStb    <= 1'b0;
      reportByte      <= 8'h00;
      reportByteValid <= 1'b0;
    end else begin
      divCnt          <= (divCnt == STB_DIV - 1) ? 0 : divCnt + 1;
      framerBitStb    <= (divCnt == 0);
      framerRxBit     <= 1'($urandom);
      reportByteValid <= ($urandom % 4 == 0);
      reportByte      <= 8'($urandom);
    end
  end
endmodule // dlcim_framer_model
